// file: rtl/usb_pingpong_bd.sv
// Descriptor selection, ping-pong pointers and USB interrupt funnel.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Function
// - four buffering modes selected by config field
// - per-endpoint pointers, forced even on enable
// - completion flips that endpoint's pointer only where it has ping-pong
// - transfer status reports last even/odd
// - pointer reset control returns all to even
// - no ping-pong: OUT 2n, IN 2n+1
// - endpoint 0 OUT ping-pong mapping
// - all ping-pong: four descriptors per endpoint
// - all but endpoint 0 mapping
// - thirty-two four-byte descriptors
// - status byte owner, toggle, count bits
// - engine writes token PID into bits 5:2
// - toggle ignored unless check enabled
// - descriptor bytes undefined after reset
// - other pair member stays free for firmware
// - all sources merge into one request flag
// - errors feed one summary top-level flag
// - top-level flags ORed into request flag
// - flags sticky until cleared, software settable
// - completion clears descriptor owner flag, except when a token to an owned descriptor lands in the same cycle
// - byte count ten bits split over bytes
// - enables gate propagation only, flags poll
module usb_pingpong_bd (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   tokValid,
    input  wire usb_bd_pkg::token_s     tokIn,
    input  wire logic                   doneValid,
    input  wire logic [9:0]             doneCount,
    input  wire logic [7:0]             statusEvents,
    input  wire logic [7:0]             errorEvents,
    output logic [4:0]                  curBdIndex,
    output logic                        curOwned,
    output logic                        curStallEn,
    output logic                        curToggleBad,
    output logic                        usbIrqRequestFlag
);

    // ------------------------------------------------------------------
    // Descriptor mapping
    // ------------------------------------------------------------------
    function automatic logic [4:0] map_bd(input usb_bd_pkg::buf_mode_e m,
                                          input logic [2:0] ep,
                                          input logic dirIn,
                                          input logic pp);
        logic [4:0] r;
        r = 5'h0_0;
        case (m)
            usb_bd_pkg::MODE_NONE: begin
                r = {1'b0, ep, dirIn};
            end
            usb_bd_pkg::MODE_EP0_OUT: begin
                if (ep == 3'h0) begin
                    r = dirIn ? 5'h0_2 : {4'h0, pp};
                end else begin
                    r = {1'b0, ep, 1'b0} + 5'h0_1 + {4'h0, dirIn};
                end
            end
            usb_bd_pkg::MODE_ALL: begin
                r = {ep, dirIn, pp};
            end
            usb_bd_pkg::MODE_ALL_BUT0: begin
                if (ep == 3'h0) begin
                    r = {4'h0, dirIn};
                end else begin
                    r = {ep, 2'b00} - 5'h0_2 + {3'h0, dirIn, pp};
                end
            end
            default: r = 5'h0_0;
        endcase
        return r;
    endfunction : map_bd

    function automatic logic has_pp(input usb_bd_pkg::buf_mode_e m,
                                    input logic [2:0] ep,
                                    input logic dirIn);
        logic r;
        r = 1'b0;
        case (m)
            usb_bd_pkg::MODE_NONE:     r = 1'b0;
            usb_bd_pkg::MODE_EP0_OUT:  r = (ep == 3'h0) && !dirIn;
            usb_bd_pkg::MODE_ALL:      r = 1'b1;
            usb_bd_pkg::MODE_ALL_BUT0: r = (ep != 3'h0);
            default:                   r = 1'b0;
        endcase
        return r;
    endfunction : has_pp

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Descriptor bytes have no reset: software must fill them first.
    logic [7:0]                 bdMem [4*usb_bd_pkg::NUM_DESC];
    usb_bd_pkg::config_s        cfg_reg;
    usb_bd_pkg::xfer_status_s   xfer_reg;
    logic [7:0]                 topFlags_reg;
    logic [7:0]                 topFlags_next;
    logic [7:0]                 topEn_reg;
    logic [7:0]                 errFlags_reg;
    logic [7:0]                 errFlags_next;
    logic [7:0]                 errEn_reg;
    logic                       irqFlag_next;
    logic                       enablePrev_reg;
    logic [15:0]                ppPtr_reg;
    logic [3:0]                 curSlot_reg;
    logic [4:0]                 curBd_reg;
    logic                       curPp_reg;
    logic [31:0]                rdata_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire        setupPhase = psel && !penable;
    wire        apbWrite   = psel && penable && pwrite;
    wire        hitDesc    = (paddr[11:9] == usb_bd_pkg::OFS_DESC_BASE[11:9]);
    wire [6:0]  descByte   = paddr[8:2];
    wire        hitCfg     = (paddr == usb_bd_pkg::OFS_CONFIG);
    wire        hitXfer    = (paddr == usb_bd_pkg::OFS_XFER_STAT);
    wire        hitTopF    = (paddr == usb_bd_pkg::OFS_TOP_FLAGS);
    wire        hitTopE    = (paddr == usb_bd_pkg::OFS_TOP_EN);
    wire        hitErrF    = (paddr == usb_bd_pkg::OFS_ERR_FLAGS);
    wire        hitErrE    = (paddr == usb_bd_pkg::OFS_ERR_EN);
    wire        hitIrq     = (paddr == usb_bd_pkg::OFS_PERIPH_IRQ);
    wire        hitAny     = hitDesc || hitCfg || hitXfer || hitTopF
                             || hitTopE || hitErrF || hitErrE || hitIrq;
    wire        badAlign   = (paddr[1:0] != 2'b00);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!hitAny || badAlign);
    assign prdata  = rdata_reg;

    wire [31:0] rdMux =
        badAlign ? usb_bd_pkg::RST_WORD :
        hitDesc  ? {24'h00_0000, bdMem[descByte]} :
        hitCfg   ? {28'h000_0000, cfg_reg.moduleEnable, 1'b0,
                    cfg_reg.bufferingModeSelect} :
        hitXfer  ? {27'h000_0000, xfer_reg} :
        hitTopF  ? {24'h00_0000, topFlags_reg} :
        hitTopE  ? {24'h00_0000, topEn_reg} :
        hitErrF  ? {24'h00_0000, errFlags_reg} :
        hitErrE  ? {24'h00_0000, errEn_reg} :
        hitIrq   ? {31'h0000_0000, usbIrqRequestFlag} :
                   usb_bd_pkg::RST_WORD;

    // Read data is latched in the setup cycle; the access answers at once.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= usb_bd_pkg::RST_WORD;
        end else if (setupPhase) begin
            rdata_reg <= rdMux;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and pointer control
    // ------------------------------------------------------------------
    wire cfgWrite   = apbWrite && hitCfg && !badAlign;
    wire enableRise = cfg_reg.moduleEnable && !enablePrev_reg;
    wire ptrClear   = enableRise || cfg_reg.pointerResetControl;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_reg        <= '0;
            enablePrev_reg <= 1'b0;
        end else begin
            enablePrev_reg <= cfg_reg.moduleEnable;
            if (cfgWrite) begin
                cfg_reg.bufferingModeSelect <=
                    usb_bd_pkg::buf_mode_e'(pwdata[1:0]);
                cfg_reg.pointerResetControl <=
                    pwdata[usb_bd_pkg::CFG_PTR_RESET];
                cfg_reg.moduleEnable        <= pwdata[usb_bd_pkg::CFG_ENABLE];
            end else begin
                cfg_reg.pointerResetControl <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Engine token and completion
    // ------------------------------------------------------------------
    wire [3:0] tokSlot  = {tokIn.ep, tokIn.dirIn};
    wire       tokPp    = ppPtr_reg[tokSlot];
    wire [4:0] tokBd    = map_bd(cfg_reg.bufferingModeSelect, tokIn.ep,
                                 tokIn.dirIn, tokPp);
    wire [6:0] tokStAdr = {tokBd, 2'b00};
    wire [7:0] tokSt    = bdMem[tokStAdr];
    wire [6:0] curStAdr = {curBd_reg, 2'b00};
    wire [6:0] curCnAdr = {curBd_reg, 2'b01};
    wire       curPpOk  = has_pp(cfg_reg.bufferingModeSelect,
                                 curSlot_reg[3:1], curSlot_reg[0]);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            curSlot_reg  <= 4'h0;
            curBd_reg    <= 5'h0_0;
            curPp_reg    <= 1'b0;
            curOwned     <= 1'b0;
            curStallEn   <= 1'b0;
            curToggleBad <= 1'b0;
        end else if (tokValid) begin
            curSlot_reg  <= tokSlot;
            curBd_reg    <= tokBd;
            curPp_reg    <= tokPp;
            curOwned     <= tokSt[usb_bd_pkg::ST_OWNER];
            curStallEn   <= tokSt[usb_bd_pkg::ST_STALL];
            // The expected toggle only matters with the check enabled.
            curToggleBad <= tokSt[usb_bd_pkg::ST_TOG_CHECK]
                            && (tokSt[usb_bd_pkg::ST_TOGGLE]
                                != tokIn.dataToggle);
        end
    end

    assign curBdIndex = curBd_reg;

    // Engine writes win over a bus write in the same cycle; the engine only
    // touches the one descriptor it holds, so its pair stays with firmware.
    always_ff @(posedge mclk) begin
        if (tokValid && tokSt[usb_bd_pkg::ST_OWNER]) begin
            bdMem[tokStAdr][5:2] <= tokIn.pid;
        end else if (doneValid) begin
            bdMem[curStAdr] <= {1'b0, bdMem[curStAdr][6:2],
                                doneCount[9:8]};
            bdMem[curCnAdr] <= doneCount[7:0];
        end else if (apbWrite && hitDesc && !badAlign) begin
            bdMem[descByte] <= pwdata[7:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < usb_bd_pkg::NUM_SLOTS; gi++) begin : g_ptr
            always_ff @(posedge mclk) begin
                if (!rst_n || ptrClear) begin
                    ppPtr_reg[gi] <= usb_bd_pkg::RST_PTRS[gi];
                end else if (doneValid && curPpOk && curSlot_reg == gi) begin
                    ppPtr_reg[gi] <= !ppPtr_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            xfer_reg <= '0;
        end else if (doneValid) begin
            xfer_reg.ep              <= curSlot_reg[3:1];
            xfer_reg.dirIn           <= curSlot_reg[0];
            xfer_reg.lastEvenOddFlag <= curPp_reg;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt funnel
    // ------------------------------------------------------------------
    // Flags set from events regardless of enables; enables gate the error summary and the request.
    wire errSummary = |(errFlags_reg & errEn_reg);
    wire topReq     = |(topFlags_reg & topEn_reg);
    wire [7:0] topSet = statusEvents
                        | (8'h01 << usb_bd_pkg::TOP_ERR_BIT) & {8{errSummary}};

    // A write stores the value, so software can clear or set; hardware wins.
    assign errFlags_next = ((apbWrite && hitErrF && !badAlign) ? pwdata[7:0]
                            : errFlags_reg) | errorEvents;
    assign topFlags_next = ((apbWrite && hitTopF && !badAlign) ? pwdata[7:0]
                            : topFlags_reg) | topSet;
    assign irqFlag_next  = ((apbWrite && hitIrq && !badAlign) ? pwdata[0]
                            : usbIrqRequestFlag) | topReq;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            topFlags_reg      <= usb_bd_pkg::RST_FLAGS;
            errFlags_reg      <= usb_bd_pkg::RST_FLAGS;
            topEn_reg         <= usb_bd_pkg::RST_FLAGS;
            errEn_reg         <= usb_bd_pkg::RST_FLAGS;
            usbIrqRequestFlag <= 1'b0;
        end else begin
            topFlags_reg      <= topFlags_next;
            errFlags_reg      <= errFlags_next;
            usbIrqRequestFlag <= irqFlag_next;
            if (apbWrite && hitTopE && !badAlign) begin
                topEn_reg <= pwdata[7:0];
            end
            if (apbWrite && hitErrE && !badAlign) begin
                errEn_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_owner_released: assert property (
        doneValid && !tokValid |=> bdMem[$past(curStAdr)][7] == 1'b0)
        else $error("owner flag not cleared after completion");

    a_pointer_flip: assert property (
        doneValid && curPpOk && !ptrClear
        |=> ppPtr_reg[$past(curSlot_reg)] != $past(ppPtr_reg[curSlot_reg]))
        else $error("pointer did not flip on completion");

    a_pointer_stays: assert property (
        doneValid && !curPpOk
        |=> ppPtr_reg == ($past(ptrClear) ? usb_bd_pkg::RST_PTRS
                                          : $past(ppPtr_reg)))
        else $error("pointer moved without ping-pong");

    a_pointer_clear: assert property (
        ptrClear |=> ppPtr_reg == usb_bd_pkg::RST_PTRS)
        else $error("pointers not returned to even");

    a_last_evenodd: assert property (
        doneValid |=> xfer_reg.lastEvenOddFlag == $past(curPp_reg))
        else $error("last even/odd flag wrong");

    a_map_none: assert property (
        tokValid && cfg_reg.bufferingModeSelect == usb_bd_pkg::MODE_NONE
        |=> curBdIndex == $past({1'b0, tokIn.ep, tokIn.dirIn}))
        else $error("descriptor index wrong without ping-pong");

    a_map_all: assert property (
        tokValid && cfg_reg.bufferingModeSelect == usb_bd_pkg::MODE_ALL
        |=> curBdIndex == $past({tokIn.ep, tokIn.dirIn, tokPp}))
        else $error("descriptor index wrong with full ping-pong");

    a_pid_stored: assert property (
        tokValid && tokSt[7]
        |=> bdMem[$past(tokStAdr)][5:2] == $past(tokIn.pid))
        else $error("token pid not stored");

    a_error_summary: assert property (
        errSummary |=> topFlags_reg[usb_bd_pkg::TOP_ERR_BIT])
        else $error("error summary flag not set");

    a_request_merge: assert property (
        topReq |=> usbIrqRequestFlag ##1 usbIrqRequestFlag || !$past(apbWrite))
        else $error("interrupt request flag not raised");

    a_flag_sticky: assert property (
        topFlags_reg[0] && !(apbWrite && hitTopF) |=> topFlags_reg[0])
        else $error("status flag dropped without software");

    a_toggle_ignored: assert property (
        tokValid && !tokSt[usb_bd_pkg::ST_TOG_CHECK] |=> !curToggleBad)
        else $error("toggle checked while check disabled");

    a_count_stored: assert property (
        doneValid && !tokValid
        |=> bdMem[$past(curCnAdr)] == $past(doneCount[7:0]))
        else $error("byte count not stored");

    a_map_ep0_plain: assert property (
        tokValid && tokIn.ep == 3'h0
        && cfg_reg.bufferingModeSelect == usb_bd_pkg::MODE_ALL_BUT0
        |=> curBdIndex == $past({4'h0, tokIn.dirIn}))
        else $error("endpoint 0 descriptor wrong in mode 3");

endmodule : usb_pingpong_bd

// file: rtl/usb_bd_pkg.sv
// Register map, field layout and carrier types of the descriptor block.
package usb_bd_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CONFIG     = 12'h0_000;
    localparam logic [11:0] OFS_XFER_STAT  = 12'h0_004;
    localparam logic [11:0] OFS_TOP_FLAGS  = 12'h0_008;
    localparam logic [11:0] OFS_TOP_EN     = 12'h0_00C;
    localparam logic [11:0] OFS_ERR_FLAGS  = 12'h0_010;
    localparam logic [11:0] OFS_ERR_EN     = 12'h0_014;
    localparam logic [11:0] OFS_PERIPH_IRQ = 12'h0_018;
    // Descriptor table window: byte address = base + 4 * (4 * n + byte).
    localparam logic [11:0] OFS_DESC_BASE  = 12'h0_200;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_PTR_RESET  = 2;
    localparam int CFG_ENABLE     = 3;
    localparam int ST_OWNER       = 7;
    localparam int ST_TOGGLE      = 6;
    localparam int ST_TOG_CHECK   = 3;
    localparam int ST_STALL       = 2;
    localparam int TOP_ERR_BIT    = 1;
    localparam int BYTE_STATUS    = 0;
    localparam int BYTE_COUNT     = 1;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int NUM_EP         = 8;
    localparam int NUM_DESC       = 32;
    localparam int NUM_SLOTS      = 16;
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_PTRS  = 16'h0000;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NONE     = 2'b00,
        MODE_EP0_OUT  = 2'b01,
        MODE_ALL      = 2'b10,
        MODE_ALL_BUT0 = 2'b11
    } buf_mode_e;

    typedef struct packed {
        logic       moduleEnable;
        logic       pointerResetControl;
        buf_mode_e  bufferingModeSelect;
    } config_s;

    typedef struct packed {
        logic [2:0] ep;
        logic       dirIn;
        logic [3:0] pid;
        logic       dataToggle;
    } token_s;

    typedef struct packed {
        logic [2:0] ep;
        logic       dirIn;
        logic       lastEvenOddFlag;
    } xfer_status_s;

endpackage : usb_bd_pkg

// file: sim/usb_engine_model.sv
// Behavioural engine side that issues tokens and completions to the block.
`timescale 1ns/10ps
module usb_engine_model (
    input  wire logic          mclk,
    output logic               tokValid,
    output usb_bd_pkg::token_s tokIn,
    output logic               doneValid,
    output logic [9:0]         doneCount
);
    initial begin
        tokValid  = 1'b0;
        tokIn     = '0;
        doneValid = 1'b0;
        doneCount = 10'h3FF;
    end

    // Released lines show the inverse of their last value, never a hold.
    task automatic token(input usb_bd_pkg::token_s t);
        @(posedge mclk);
        tokValid <= 1'b1;
        tokIn    <= t;
        @(posedge mclk);
        tokValid <= 1'b0;
        tokIn    <= ~t;
    endtask : token

    // A completion always starts after its token has been released.
    task automatic done(input logic [9:0] c);
        @(posedge mclk);
        doneValid <= 1'b1;
        doneCount <= c;
        @(posedge mclk);
        doneValid <= 1'b0;
        doneCount <= ~c;
    endtask : done
endmodule : usb_engine_model

// file: sim/usb_pingpong_bd_bench.sv
// Self-checking bench for descriptor selection and the interrupt funnel.
`timescale 1ns/10ps
module usb_pingpong_bd_bench;
    logic               mclk;
    logic               rst_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               tokValid;
    usb_bd_pkg::token_s tokIn;
    logic               doneValid;
    logic [9:0]         doneCount;
    logic [7:0]         statusEvents;
    logic [7:0]         errorEvents;
    logic [4:0]         curBdIndex;
    logic               curOwned;
    logic               curStallEn;
    logic               curToggleBad;
    logic               irq;
    logic [31:0]        rdv;
    logic               erv;
    int                 error_cnt;
    int                 checked;
    int                 cycles;

    usb_pingpong_bd dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tokValid(tokValid), .tokIn(tokIn),
        .doneValid(doneValid), .doneCount(doneCount),
        .statusEvents(statusEvents), .errorEvents(errorEvents),
        .curBdIndex(curBdIndex), .curOwned(curOwned),
        .curStallEn(curStallEn), .curToggleBad(curToggleBad),
        .usbIrqRequestFlag(irq));

    usb_engine_model eng (.mclk(mclk), .tokValid(tokValid),
        .tokIn(tokIn), .doneValid(doneValid), .doneCount(doneCount));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv, e);
        chk(32'(erv), 32'h0000_0000);
    endtask : rdc

    function automatic logic [11:0] bd(input int n, input int k);
        return usb_bd_pkg::OFS_DESC_BASE + 12'(16 * n + 4 * k);
    endfunction : bd

    function automatic logic [4:0] expIdx(input logic [1:0] m,
        input logic [2:0] e, input logic d, input logic p);
        case (m)
            2'b00: return 5'(2 * e + d);
            2'b01: return (e == 0 && !d) ? 5'(p) : 5'(2 * e + d + 1);
            2'b10: return 5'(4 * e + 2 * d + p);
            default: return (e == 0) ? 5'(d) : 5'(4 * e - 2 + 2 * d + p);
        endcase
    endfunction : expIdx

    task automatic tok(input logic [2:0] e, input logic d,
                       input logic [3:0] pid, input logic [4:0] x);
        // The data toggle follows pid bit 3 so both toggle values occur.
        eng.token('{ep: e, dirIn: d, pid: pid, dataToggle: pid[3]});
        @(negedge mclk);
        chk(32'(curBdIndex), 32'(x));
    endtask : tok

    task automatic pulse(input logic [7:0] s, input logic [7:0] e);
        @(posedge mclk);
        statusEvents <= s;
        errorEvents  <= e;
        @(posedge mclk);
        statusEvents <= 8'h00;
        errorEvents  <= 8'h00;
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc(usb_bd_pkg::OFS_XFER_STAT, usb_bd_pkg::RST_WORD);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, usb_bd_pkg::RST_WORD);
        apb(1'b1, usb_bd_pkg::OFS_XFER_STAT, 32'h0000_001F);
        rdc(usb_bd_pkg::OFS_XFER_STAT, usb_bd_pkg::RST_WORD);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk(32'(erv), 32'h0000_0001);
        chk(rdv, usb_bd_pkg::RST_WORD);
        apb(1'b0, 12'h006, 32'h0000_0000);
        chk(32'(erv), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
    endtask : t_reset

    task automatic t_map();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'(8 + m));
            for (int k = 0; k < 16; k++) begin
                tok(3'(k >> 1), k[0], 4'h1,
                    expIdx(2'(m), 3'(k >> 1), k[0], 1'b0));
            end
        end
    endtask : t_map

    task automatic t_pingpong();
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_000A);
        tok(3'd3, 1'b0, 4'h1, 5'd12);
        eng.done(10'h001);
        rdc(usb_bd_pkg::OFS_XFER_STAT, 32'h0000_000C);
        tok(3'd3, 1'b0, 4'h1, 5'd13);
        apb(1'b1, bd(12, 2), 32'h0000_005A);
        rdc(bd(12, 2), 32'h0000_005A);
        eng.done(10'h001);
        rdc(usb_bd_pkg::OFS_XFER_STAT, 32'h0000_000D);
        tok(3'd3, 1'b0, 4'h1, 5'd12);
        eng.done(10'h001);
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_000E);
        tok(3'd3, 1'b0, 4'h1, 5'd12);
        eng.done(10'h001);
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_0002);
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_000A);
        tok(3'd3, 1'b0, 4'h1, 5'd12);
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_0009);
        tok(3'd0, 1'b0, 4'h1, 5'd0);
        eng.done(10'h001);
        tok(3'd0, 1'b0, 4'h1, 5'd1);
        tok(3'd1, 1'b0, 4'h1, 5'd3);
        eng.done(10'h001);
        tok(3'd1, 1'b0, 4'h1, 5'd3);
    endtask : t_pingpong

    task automatic t_desc();
        apb(1'b1, usb_bd_pkg::OFS_CONFIG, 32'h0000_0008);
        apb(1'b1, bd(11, 1), 32'h0000_0000);
        apb(1'b1, bd(11, 2), 32'h0000_0034);
        apb(1'b1, bd(11, 0), 32'h0000_004C);
        apb(1'b1, bd(11, 0), 32'h0000_00CC);
        tok(3'd5, 1'b1, 4'h1, 5'd11);
        chk({curOwned, curStallEn}, 32'h0000_0003);
        chk(32'(curToggleBad), 32'h0000_0001);
        rdc(bd(11, 0), 32'h0000_00C4);
        eng.done(10'h2A5);
        rdc(bd(11, 0), 32'h0000_0046);
        rdc(bd(11, 1), 32'h0000_00A5);
        rdc(bd(11, 2), 32'h0000_0034);
        apb(1'b1, bd(11, 0), 32'h0000_0000);
        apb(1'b1, bd(11, 0), 32'h0000_0080);
        tok(3'd5, 1'b1, 4'h9, 5'd11);
        chk({curToggleBad, curStallEn}, 32'h0000_0000);
        eng.done(10'h000);
    endtask : t_desc

    task automatic t_irq();
        pulse(8'h01, 8'h04);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0001);
        rdc(usb_bd_pkg::OFS_ERR_FLAGS, 32'h0000_0004);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, usb_bd_pkg::OFS_ERR_EN, 32'h0000_0004);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0003);
        rdc(usb_bd_pkg::OFS_ERR_FLAGS, 32'h0000_0004);
        apb(1'b1, usb_bd_pkg::OFS_TOP_EN, 32'h0000_0002);
        rdc(usb_bd_pkg::OFS_PERIPH_IRQ, 32'h0000_0001);
        apb(1'b1, usb_bd_pkg::OFS_ERR_FLAGS, 32'h0000_0000);
        apb(1'b1, usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0000);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0000);
        apb(1'b1, usb_bd_pkg::OFS_PERIPH_IRQ, 32'h0000_0000);
        @(negedge mclk);
        chk(32'(irq), 32'h0000_0000);
        pulse(8'h10, 8'h08);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0010);
        rdc(usb_bd_pkg::OFS_ERR_FLAGS, 32'h0000_0008);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0080);
        apb(1'b1, usb_bd_pkg::OFS_TOP_EN, 32'h0000_0080);
        rdc(usb_bd_pkg::OFS_TOP_FLAGS, 32'h0000_0080);
        chk(32'(irq), 32'h0000_0001);
    endtask : t_irq

    initial begin
        rst_n        = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = '0;
        pwdata       = '0;
        statusEvents = '0;
        errorEvents  = '0;
        error_cnt    = 0;
        checked      = 0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_map();
        t_pingpong();
        t_desc();
        t_irq();
        complete_run();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        cycles = 0;
        forever begin
            @(posedge mclk);
            cycles++;
            if (cycles == 5000) begin
                error_cnt++;
                $display("MISMATCH %0t run did not finish", $time);
                complete_run();
            end
        end
    end
endmodule : usb_pingpong_bd_bench
